// file: design/bridge_cfg_pkg.sv
/*
 * shared constants and carriers for the bridge bus number, i/o window and
 * secondary status block. assumes a 32-bit apb register bus.
 */
package bridge_cfg_pkg;

    // byte offsets on the apb bus
    localparam logic [11:0] OFF_BUS_NUM = 12'h018;
    localparam logic [11:0] OFF_IO_STS = 12'h01c;
    localparam logic [11:0] OFF_IO_UPPER = 12'h030;
    localparam logic [11:0] OFF_CTRL = 12'h03c;
    localparam logic [11:0] OFF_IRQ_STS = 12'h040;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h044;

    // field positions
    localparam int SEC_BUS_LSB = 8;
    localparam int SUB_BUS_LSB = 16;
    localparam int LAT_TMR_LSB = 24;
    localparam int IO_BASE_LSB = 4;
    localparam int IO_LIMIT_LSB = 12;
    localparam int IO_BASE_CAP_LSB = 0;
    localparam int IO_LIMIT_CAP_LSB = 8;
    localparam int STS_PERR_BIT = 24;
    localparam int STS_ABORT_LSB = 27;
    localparam int CTRL_PERR_EN_BIT = 0;
    localparam int CTRL_SERR_EN_BIT = 1;

    // fixed field values
    localparam logic [7:0] LAT_TMR_VAL = 8'h00;
    localparam logic [3:0] IO_CAP_32BIT = 4'h1;
    localparam logic [11:0] IO_LOW_BASE = 12'h000;
    localparam logic [11:0] IO_LOW_LIMIT = 12'hfff;

    // reset values
    localparam logic [7:0] BUS_NUM_RST = 8'h00;
    localparam logic [3:0] IO_WIN_RST = 4'h0;
    localparam logic [15:0] IO_UPPER_RST = 16'h0000;

    // event index, shared by the secondary status and interrupt bits
    localparam int EV_PERR = 0;
    localparam int EV_SIG_CA = 1;
    localparam int EV_RX_CA = 2;
    localparam int EV_RX_UR = 3;
    localparam int EV_SERR = 4;
    localparam int EV_POISON = 5;
    localparam int EV_N = 6;
    // events whose status bit is write-one-to-clear in the status register
    localparam logic [EV_N-1:0] EV_W1C = 6'h31;
    localparam logic [EV_N-1:0] EV_NONE = 6'h00;

    typedef struct packed {
        logic [7:0] sec_bus;
        logic [7:0] sub_bus;
        logic [3:0] io_base;
        logic [3:0] io_limit;
        logic [15:0] io_base_hi;
        logic [15:0] io_limit_hi;
        logic perr_resp_en;
        logic serr_en;
        logic [EV_N-1:0] sts;
        logic [EV_N-1:0] irq_sts;
        logic [EV_N-1:0] irq_mask;
        logic [31:0] rdata;
        logic slverr;
        logic rd_ready;
        logic fwd_valid;
        logic fwd_hit;
    } bridge_state_s;

    localparam bridge_state_s STATE_RST = '{
        sec_bus: BUS_NUM_RST,
        sub_bus: BUS_NUM_RST,
        io_base: IO_WIN_RST,
        io_limit: IO_WIN_RST,
        io_base_hi: IO_UPPER_RST,
        io_limit_hi: IO_UPPER_RST,
        perr_resp_en: 1'b0,
        serr_en: 1'b0,
        sts: EV_NONE,
        irq_sts: EV_NONE,
        irq_mask: EV_NONE,
        rdata: 32'h0000_0000,
        slverr: 1'b0,
        rd_ready: 1'b0,
        fwd_valid: 1'b0,
        fwd_hit: 1'b0
    };

endpackage : bridge_cfg_pkg

// file: design/io_window_match.sv
/*
 * inclusive address range compare for the forwarded i/o window.
 * assumes bounds already assembled to full width by the caller.
 */
`timescale 1ns/10ps
module io_window_match #(
    parameter int AW = 32
) (
    input wire logic [AW-1:0] i_addr,
    input wire logic [AW-1:0] i_base,
    input wire logic [AW-1:0] i_limit,
    output logic o_hit
);

    // R07 both bounds included
    // base above limit gives no hit, which closes the window
    assign o_hit = (i_addr >= i_base) && (i_addr <= i_limit);

endmodule : io_window_match

// file: design/bridge_bus_io_window_secondary_status.sv
/*
 * bus numbers, i/o window and secondary status of one bridge port,
 * reached over apb, with sticky event interrupt and window compare.
 * assumes event inputs are one-cycle pulses on i_clk_sys.
 */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// R01: subordinate bus number byte at bits 23:16, software writes it, resets zero.
// R02: secondary latency timer byte 31:24 reads zero, writes ignored.
// R03: i/o base 3:0 and limit 11:8 read one, 32-bit i/o decode.
// R04: i/o base 7:4 gives address 15:12 of window bottom, low bits zero.
// R05: i/o limit 15:12 gives address 15:12 of window top, low bits ones.
// R06: window address 31:16 comes from the upper base and limit registers.
// R07: forward i/o request when address lies within base and limit, inclusive.
// R08: status bits 21, 23, 26:25 read zero; 20:16, 22 reserved.
// R09: bit 24 sets on secondary parity error when response enable set; w1c.
// R10: bit 27 sets when port completes secondary request with completer abort.
// R11: bit 28 sets on secondary completion received with completer abort.
// R12: bit 29 sets on secondary completion received with unsupported request.
// R13: bit 30 sets on sent error message while error report enabled; w1c.
// R14: bit 31 sets on poisoned tlp received on secondary side; w1c.
// R15: w1c bits clear only on written one; read-only flags never cleared.
// R16: secondary bus number byte at bits 15:8, software writes it, resets zero.
module bridge_bus_io_window_secondary_status #(
    parameter int AW = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sec_parity_err,
    input wire logic i_sec_cpl_abort_sent,
    input wire logic i_sec_rx_cpl_abort,
    input wire logic i_sec_rx_cpl_ur,
    input wire logic i_err_msg_sent,
    input wire logic i_sec_rx_poisoned,
    input wire logic i_io_req_valid,
    input wire logic [AW-1:0] i_io_req_addr,
    output logic o_io_fwd_valid,
    output logic o_io_fwd_hit,
    output logic [7:0] o_sec_bus,
    output logic [7:0] o_sub_bus,
    output logic [AW-1:0] o_io_win_base,
    output logic [AW-1:0] o_io_win_limit,
    output logic o_irq
);

    bridge_cfg_pkg::bridge_state_s s_r;
    bridge_cfg_pkg::bridge_state_s s_nxt;

    logic [AW-1:0] win_base;
    logic [AW-1:0] win_limit;
    logic win_hit;
    logic [bridge_cfg_pkg::EV_N-1:0] ev;
    logic [bridge_cfg_pkg::EV_N-1:0] sts_clr;
    logic [bridge_cfg_pkg::EV_N-1:0] irq_clr;
    logic wr;
    logic addr_ok;
    logic [31:0] rd_word;
    logic [31:0] w_bus;
    logic [31:0] w_io;
    logic [31:0] w_up;
    logic [31:0] w_ctrl;
    logic [31:0] w_irqs;
    logic [31:0] w_mask;
    logic [31:0] lane_mask;

    // R04 bottom, low twelve address bits zero
    // R06 upper half from the upper base register
    // other widths than 32 zero-extend or drop the top of the assembled bound
    assign win_base = AW'({s_r.io_base_hi, s_r.io_base, bridge_cfg_pkg::IO_LOW_BASE});
    // R05 top, low twelve address bits ones
    // R06 upper half from the upper limit register
    assign win_limit = AW'({s_r.io_limit_hi, s_r.io_limit, bridge_cfg_pkg::IO_LOW_LIMIT});

    io_window_match #(
        .AW(AW)
    ) u_match (
        .i_addr(i_io_req_addr),
        .i_base(win_base),
        .i_limit(win_limit),
        .o_hit(win_hit)
    );

    // R09 parity flag gated by response enable
    assign ev[bridge_cfg_pkg::EV_PERR] = i_sec_parity_err & s_r.perr_resp_en;
    // R10 completer abort signalled
    assign ev[bridge_cfg_pkg::EV_SIG_CA] = i_sec_cpl_abort_sent;
    // R11 completer abort received
    assign ev[bridge_cfg_pkg::EV_RX_CA] = i_sec_rx_cpl_abort;
    // R12 unsupported request received
    assign ev[bridge_cfg_pkg::EV_RX_UR] = i_sec_rx_cpl_ur;
    // R13 error message gated by report enable
    assign ev[bridge_cfg_pkg::EV_SERR] = i_err_msg_sent & s_r.serr_en;
    // R14 poisoned tlp received
    assign ev[bridge_cfg_pkg::EV_POISON] = i_sec_rx_poisoned;

    // a write lands only on the edge that answers it, never twice in a stall
    assign wr = i_psel & i_penable & i_pwrite & s_r.rd_ready;

    // byte lanes that a write may touch
    always_comb begin
        lane_mask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    end

    // write data per register, zero when not addressed
    always_comb begin
        w_bus = 32'h0000_0000;
        w_io = 32'h0000_0000;
        w_up = 32'h0000_0000;
        w_ctrl = 32'h0000_0000;
        w_irqs = 32'h0000_0000;
        w_mask = 32'h0000_0000;
        if (wr) begin
            unique case (i_paddr)
                bridge_cfg_pkg::OFF_BUS_NUM: begin
                    w_bus = i_pwdata & lane_mask;
                end
                bridge_cfg_pkg::OFF_IO_STS: begin
                    w_io = i_pwdata & lane_mask;
                end
                bridge_cfg_pkg::OFF_IO_UPPER: begin
                    w_up = i_pwdata & lane_mask;
                end
                bridge_cfg_pkg::OFF_CTRL: begin
                    w_ctrl = i_pwdata & lane_mask;
                end
                bridge_cfg_pkg::OFF_IRQ_STS: begin
                    w_irqs = i_pwdata & lane_mask;
                end
                bridge_cfg_pkg::OFF_IRQ_MASK: begin
                    w_mask = i_pwdata & lane_mask;
                end
                default: begin
                end
            endcase
        end
    end

    // R15 one clears, zero keeps; abort flags have no clear path
    always_comb begin
        sts_clr = bridge_cfg_pkg::EV_NONE;
        sts_clr[bridge_cfg_pkg::EV_PERR] = w_io[bridge_cfg_pkg::STS_PERR_BIT];
        sts_clr[bridge_cfg_pkg::EV_SERR] = w_io[bridge_cfg_pkg::STS_ABORT_LSB + 3];
        sts_clr[bridge_cfg_pkg::EV_POISON] = w_io[bridge_cfg_pkg::STS_ABORT_LSB + 4];
        sts_clr = sts_clr & bridge_cfg_pkg::EV_W1C;
        irq_clr = w_irqs[bridge_cfg_pkg::EV_N-1:0];
    end

    // address decode for the slave error answer
    always_comb begin
        unique case (i_paddr)
            bridge_cfg_pkg::OFF_BUS_NUM,
            bridge_cfg_pkg::OFF_IO_STS,
            bridge_cfg_pkg::OFF_IO_UPPER,
            bridge_cfg_pkg::OFF_CTRL,
            bridge_cfg_pkg::OFF_IRQ_STS,
            bridge_cfg_pkg::OFF_IRQ_MASK: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // read mux; unlisted bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (i_paddr)
            bridge_cfg_pkg::OFF_BUS_NUM: begin
                // R16 secondary bus byte
                rd_word[bridge_cfg_pkg::SEC_BUS_LSB +: 8] = s_r.sec_bus;
                // R01 subordinate bus byte
                rd_word[bridge_cfg_pkg::SUB_BUS_LSB +: 8] = s_r.sub_bus;
                // R02 latency timer fixed
                rd_word[bridge_cfg_pkg::LAT_TMR_LSB +: 8] = bridge_cfg_pkg::LAT_TMR_VAL;
            end
            bridge_cfg_pkg::OFF_IO_STS: begin
                // R03 32-bit decode nibbles
                rd_word[bridge_cfg_pkg::IO_BASE_CAP_LSB +: 4] = bridge_cfg_pkg::IO_CAP_32BIT;
                rd_word[bridge_cfg_pkg::IO_LIMIT_CAP_LSB +: 4] = bridge_cfg_pkg::IO_CAP_32BIT;
                rd_word[bridge_cfg_pkg::IO_BASE_LSB +: 4] = s_r.io_base;
                rd_word[bridge_cfg_pkg::IO_LIMIT_LSB +: 4] = s_r.io_limit;
                // R08 bits 23:16 and 26:25 stay zero
                rd_word[bridge_cfg_pkg::STS_PERR_BIT] = s_r.sts[bridge_cfg_pkg::EV_PERR];
                rd_word[bridge_cfg_pkg::STS_ABORT_LSB +: 5] = s_r.sts[bridge_cfg_pkg::EV_N-1:1];
            end
            bridge_cfg_pkg::OFF_IO_UPPER: begin
                rd_word = {s_r.io_limit_hi, s_r.io_base_hi};
            end
            bridge_cfg_pkg::OFF_CTRL: begin
                rd_word[bridge_cfg_pkg::CTRL_PERR_EN_BIT] = s_r.perr_resp_en;
                rd_word[bridge_cfg_pkg::CTRL_SERR_EN_BIT] = s_r.serr_en;
            end
            bridge_cfg_pkg::OFF_IRQ_STS: begin
                rd_word[bridge_cfg_pkg::EV_N-1:0] = s_r.irq_sts;
            end
            bridge_cfg_pkg::OFF_IRQ_MASK: begin
                rd_word[bridge_cfg_pkg::EV_N-1:0] = s_r.irq_mask;
            end
            default: begin
            end
        endcase
    end

    // next state
    always_comb begin
        s_nxt = s_r;
        // read data taken on the first enabled edge of a transfer so it leaves a flop;
        // a setup edge lost to a low clock enable is made up in the access phase
        if (i_psel && !s_r.rd_ready) begin
            s_nxt.rdata = i_pwrite ? 32'h0000_0000 : rd_word;
            s_nxt.slverr = ~addr_ok;
            s_nxt.rd_ready = 1'b1;
        end
        // the answered access frees the capture for the next setup
        if (o_pready) begin
            s_nxt.rd_ready = 1'b0;
        end
        // R16 secondary bus byte write
        if (i_pstrb[1] && wr && i_paddr == bridge_cfg_pkg::OFF_BUS_NUM) begin
            s_nxt.sec_bus = w_bus[bridge_cfg_pkg::SEC_BUS_LSB +: 8];
        end
        // R01 subordinate bus byte write
        if (i_pstrb[2] && wr && i_paddr == bridge_cfg_pkg::OFF_BUS_NUM) begin
            s_nxt.sub_bus = w_bus[bridge_cfg_pkg::SUB_BUS_LSB +: 8];
        end
        // R04 base nibble write
        if (i_pstrb[0] && wr && i_paddr == bridge_cfg_pkg::OFF_IO_STS) begin
            s_nxt.io_base = w_io[bridge_cfg_pkg::IO_BASE_LSB +: 4];
        end
        // R05 limit nibble write
        if (i_pstrb[1] && wr && i_paddr == bridge_cfg_pkg::OFF_IO_STS) begin
            s_nxt.io_limit = w_io[bridge_cfg_pkg::IO_LIMIT_LSB +: 4];
        end
        // R06 upper halves, one lane at a time
        if (wr && i_paddr == bridge_cfg_pkg::OFF_IO_UPPER) begin
            s_nxt.io_base_hi = (s_r.io_base_hi & ~lane_mask[15:0]) | w_up[15:0];
            s_nxt.io_limit_hi = (s_r.io_limit_hi & ~lane_mask[31:16]) | w_up[31:16];
        end
        // R09 parity response enable
        if (i_pstrb[0] && wr && i_paddr == bridge_cfg_pkg::OFF_CTRL) begin
            s_nxt.perr_resp_en = w_ctrl[bridge_cfg_pkg::CTRL_PERR_EN_BIT];
        end
        // R13 error report enable
        if (i_pstrb[0] && wr && i_paddr == bridge_cfg_pkg::OFF_CTRL) begin
            s_nxt.serr_en = w_ctrl[bridge_cfg_pkg::CTRL_SERR_EN_BIT];
        end
        // mask only gates o_irq; status bits keep collecting events
        if (i_pstrb[0] && wr && i_paddr == bridge_cfg_pkg::OFF_IRQ_MASK) begin
            s_nxt.irq_mask = w_mask[bridge_cfg_pkg::EV_N-1:0];
        end
        // R15 set wins over a clear in the same cycle
        s_nxt.sts = (s_r.sts & ~sts_clr) | ev;
        s_nxt.irq_sts = (s_r.irq_sts & ~irq_clr) | ev;
        // R07 compare result registered one cycle after the request
        s_nxt.fwd_valid = i_io_req_valid;
        s_nxt.fwd_hit = i_io_req_valid & win_hit;
    end

    // clock enable low freezes every flop
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= bridge_cfg_pkg::STATE_RST;
        end else if (i_clk_en) begin
            s_r <= s_nxt;
        end
    end

    // access phase completes only on an enabled edge after the read data was taken;
    // a frozen clock only stretches the access phase, nothing is lost
    assign o_pready = i_psel & i_penable & i_clk_en & s_r.rd_ready;
    assign o_prdata = s_r.rdata;
    assign o_pslverr = s_r.slverr & o_pready;

    assign o_io_fwd_valid = s_r.fwd_valid;
    assign o_io_fwd_hit = s_r.fwd_hit;
    assign o_sec_bus = s_r.sec_bus;
    assign o_sub_bus = s_r.sub_bus;
    assign o_io_win_base = win_base;
    assign o_io_win_limit = win_limit;
    // level interrupt from unmasked sticky bits
    assign o_irq = |(s_r.irq_sts & s_r.irq_mask);

endmodule : bridge_bus_io_window_secondary_status

// file: verification/bridge_cfg_asserts.sv
/* port-level checks of the bridge bus number, i/o window and status block.
   assumes one-cycle event pulses; apb may wait while the clock enable is low. */
`timescale 1ns/10ps
module bridge_cfg_asserts #(
    parameter int AW = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic i_io_req_valid,
    input wire logic [AW-1:0] i_io_req_addr,
    input wire logic o_io_fwd_valid,
    input wire logic o_io_fwd_hit,
    input wire logic [7:0] o_sec_bus,
    input wire logic [7:0] o_sub_bus,
    input wire logic [AW-1:0] o_io_win_base,
    input wire logic [AW-1:0] o_io_win_limit,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic in_win;
    assign in_win = i_io_req_addr >= o_io_win_base && i_io_req_addr <= o_io_win_limit;
    sequence s_wr(logic [11:0] a);
        i_psel && i_penable && i_pwrite && o_pready && i_paddr == a;
    endsequence
    sequence s_rd(logic [11:0] a);
        i_psel && i_penable && !i_pwrite && o_pready && i_paddr == a;
    endsequence
    a_sub_bus_store: assert property (s_wr(12'h018) ##0 i_pstrb[2] |=>
        o_sub_bus == $past(i_pwdata[23:16])) else $error("sub bus not stored");
    a_sec_bus_store: assert property (s_wr(12'h018) ##0 i_pstrb[1] |=>
        o_sec_bus == $past(i_pwdata[15:8])) else $error("sec bus not stored");
    a_latency_zero: assert property (s_rd(12'h018) |->
        o_prdata[31:24] == 8'h00) else $error("latency byte not zero");
    a_io_caps_one: assert property (s_rd(12'h01c) |->
        o_prdata[3:0] == 4'h1 && o_prdata[11:8] == 4'h1) else $error("io caps wrong");
    a_base_store: assert property (s_wr(12'h01c) ##0 i_pstrb[0] |=>
        o_io_win_base[15:0] == {$past(i_pwdata[7:4]), 12'h000}) else $error("base wrong");
    a_limit_store: assert property (s_wr(12'h01c) ##0 i_pstrb[1] |=>
        o_io_win_limit[15:0] == {$past(i_pwdata[15:12]), 12'hfff}) else $error("limit wrong");
    a_upper_store: assert property (s_wr(12'h030) ##0 i_pstrb[1:0] == 2'b11 |=>
        o_io_win_base[31:16] == $past(i_pwdata[15:0])) else $error("upper base wrong");
    a_fwd_range: assert property (i_clk_en && i_io_req_valid |=>
        o_io_fwd_valid && o_io_fwd_hit == $past(in_win)) else $error("forward decision wrong");
    a_status_zeros: assert property (s_rd(12'h01c) |->
        o_prdata[26:25] == 2'b00 && !o_prdata[23] && !o_prdata[21]) else $error("status zeros");
    // irq may only drop after software wrote something
    a_irq_sticky: assert property ($fell(o_irq) |->
        $past(i_psel && i_penable && i_pwrite)) else $error("irq dropped by itself");
endmodule : bridge_cfg_asserts

bind bridge_bus_io_window_secondary_status bridge_cfg_asserts #(.AW(AW)) bridge_cfg_asserts_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
    .i_io_req_valid(i_io_req_valid), .i_io_req_addr(i_io_req_addr),
    .o_io_fwd_valid(o_io_fwd_valid), .o_io_fwd_hit(o_io_fwd_hit), .o_sec_bus(o_sec_bus),
    .o_sub_bus(o_sub_bus), .o_io_win_base(o_io_win_base), .o_io_win_limit(o_io_win_limit),
    .o_irq(o_irq)
);

// file: verification/host_cfg_model.sv
/* apb master standing in for host configuration software.
   assumes the slave answers with pready; gives up after 50 cycles. */
`timescale 1ns/10ps
module host_cfg_model (
    input wire logic i_clk_sys,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    output logic o_psel = 1'b0,
    output logic o_penable = 1'b0,
    output logic o_pwrite = 1'b0,
    output logic [11:0] o_paddr = 12'h000,
    output logic [31:0] o_pwdata = 32'h0000_0000,
    // full-word writes, so only lanes holding ones can clear
    output logic [3:0] o_pstrb = 4'hf,
    output logic o_hang = 1'b0
);
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        int n;
        @(posedge i_clk_sys);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (i_pready !== 1'b1 && n < 50);
        o_hang <= (i_pready !== 1'b1);
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // released lines show garbage, not the last value
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask : xfer
endmodule : host_cfg_model

// file: verification/bridge_bus_io_window_secondary_status_tb.sv
/* self-checking bench: apb register tests, window probes, status events.
   assumes host_cfg_model as bus master and a 20 mhz clock. */
`timescale 1ns/10ps
module bridge_bus_io_window_secondary_status_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [5:0] ev = 6'h00;
    logic req_v = 1'b0;
    logic [31:0] req_a = 32'h0000_0000;
    logic psel, penable, pwrite, pready, pslverr, hang, fwd_v, fwd_h, irq, e;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, wbase, wlim, q, sts;
    logic [7:0] sec, sub;
    int miscompares = 0;
    int comparisons = 0;
    int pos [6] = '{24, 27, 28, 29, 30, 31};
    always #25 i_clk_sys = ~i_clk_sys;
    host_cfg_model host_cfg_model_inst (.i_clk_sys(i_clk_sys), .i_pready(pready),
        .i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb), .o_hang(hang));
    bridge_bus_io_window_secondary_status #(.AW(32)) bridge_bus_io_window_secondary_status_inst (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_en(clk_en), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sec_parity_err(ev[0]), .i_sec_cpl_abort_sent(ev[1]), .i_sec_rx_cpl_abort(ev[2]),
        .i_sec_rx_cpl_ur(ev[3]), .i_err_msg_sent(ev[4]), .i_sec_rx_poisoned(ev[5]),
        .i_io_req_valid(req_v), .i_io_req_addr(req_a), .o_io_fwd_valid(fwd_v),
        .o_io_fwd_hit(fwd_h), .o_sec_bus(sec), .o_sub_bus(sub), .o_io_win_base(wbase),
        .o_io_win_limit(wlim), .o_irq(irq));
    task check(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    always @(posedge hang) begin
        miscompares++;
        final_report();
    end
    task wr(input logic [11:0] a, input logic [31:0] d);
        host_cfg_model_inst.xfer(1'b1, a, d, q, e);
        // let the edge that lands the write settle before anyone looks
        #1;
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] x);
        host_cfg_model_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
        check("rdata", q, x);
    endtask : rd
    task probe(input logic [31:0] a, input logic x);
        @(posedge i_clk_sys);
        req_v <= 1'b1;
        req_a <= a;
        @(posedge i_clk_sys);
        req_v <= 1'b0;
        #1;
        check("fwd", {fwd_v, fwd_h}, {1'b1, x});
    endtask : probe
    task pulse(input int i);
        @(posedge i_clk_sys);
        ev <= 6'h01 << i;
        @(posedge i_clk_sys);
        ev <= 6'h00;
        #1;
    endtask : pulse
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rd(12'h018, 32'h0000_0000);
        rd(12'h01c, 32'h0000_0101);
        rd(12'h030, 32'h0000_0000);
        check("limit", wlim, 32'h0000_0fff);
        $display("test reset done");
        wr(12'h018, 32'hffff_ffff);
        rd(12'h018, 32'h00ff_ff00);
        wr(12'h018, 32'h0012_3400);
        check("buses", {sec, sub}, 32'h0000_3412);
        $display("test bus numbers done");
        wr(12'h01c, 32'h0000_5020);
        wr(12'h030, 32'h0001_0001);
        rd(12'h01c, 32'h0000_5121);
        check("base", wbase, 32'h0001_2000);
        check("limit", wlim, 32'h0001_5fff);
        probe(32'h0001_1fff, 1'b0);
        probe(32'h0001_2000, 1'b1);
        probe(32'h0001_5fff, 1'b1);
        probe(32'h0001_6000, 1'b0);
        probe(32'h0000_3000, 1'b0);
        $display("test io window done");
        // both enables still off, so these two must be ignored
        pulse(0);
        pulse(4);
        rd(12'h01c, 32'h0000_5121);
        wr(12'h03c, 32'h0000_0003);
        wr(12'h044, 32'h0000_003f);
        sts = 32'h0000_5121;
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            sts[pos[i]] = 1'b1;
            check("irq", irq, 1'b1);
            rd(12'h01c, sts);
            rd(12'h040, 32'h0000_0001 << i);
            wr(12'h040, 32'h0000_0001 << i);
            check("irq", irq, 1'b0);
            wr(12'h01c, 32'h0000_5020 | (32'h0000_0001 << pos[i]));
            if (bridge_cfg_pkg::EV_W1C[i]) sts[pos[i]] = 1'b0;
            rd(12'h01c, sts);
        end
        wr(12'h044, 32'h0000_0000);
        pulse(5);
        check("irq", irq, 1'b0);
        wr(12'h01c, 32'h0000_5020);
        rd(12'h01c, 32'hb800_5121);
        $display("test status events done");
        host_cfg_model_inst.xfer(1'b0, 12'h100, 32'h0000_0000, q, e);
        check("unmapped rdata", q, 32'h0000_0000);
        check("slverr", {31'h0000_0000, e}, 32'h0000_0001);
        wr(12'h100, 32'hffff_ffff);
        rd(12'h018, 32'h0012_3400);
        $display("test unmapped done");
        i_rst_n <= 1'b0;
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rd(12'h01c, 32'h0000_0101);
        $display("test mid-run reset done");
        wr(12'h018, 32'h0000_5500);
        // setup edge and an event both fall while the clock enable is low
        fork
            rd(12'h018, 32'h0000_5500);
            begin
                @(posedge i_clk_sys);
                clk_en <= 1'b0;
                pulse(5);
                clk_en <= 1'b1;
            end
        join
        rd(12'h01c, 32'h0000_0101);
        $display("test clock enable done");
        final_report();
    end
endmodule : bridge_bus_io_window_secondary_status_tb
